// ---- src/pwct_map.vh ----
// register map, field positions, reset values and mode codes of the pulse width counter timer
`ifndef PWCT_MAP_VH
`define PWCT_MAP_VH

// ****************************************
// register offsets (4-bit word address)
// ****************************************
`define PWCT_ADDR_CTRL      4'h0
`define PWCT_ADDR_RELOAD    4'h1
`define PWCT_ADDR_COUNT     4'h2
`define PWCT_ADDR_RESULT    4'h3
`define PWCT_ADDR_STATUS    4'h4
`define PWCT_ADDR_MASK      4'h5
`define PWCT_ADDR_DIVSEL    4'h6

// ****************************************
// control register fields
// ****************************************
`define PWCT_CTRL_RUN       0
`define PWCT_CTRL_MODE_LO   1
`define PWCT_CTRL_MODE_HI   3
`define PWCT_CTRL_CLK_LO    4
`define PWCT_CTRL_CLK_HI    5
`define PWCT_CTRL_CONT      6
`define PWCT_CTRL_WIDTH     7
`define PWCT_CTRL_RESET     7'h00

// ****************************************
// operating modes
// ****************************************
`define PWCT_MODE_TIMER     3'h0
`define PWCT_MODE_HIGH      3'h1
`define PWCT_MODE_LOW       3'h2
`define PWCT_MODE_RISE_CYC  3'h3
`define PWCT_MODE_FALL_CYC  3'h4
`define PWCT_MODE_EDGE      3'h5

// ****************************************
// count clock selection: prescale terminal counts
// ****************************************
`define PWCT_PRE_WIDTH      8
`define PWCT_PRE_DIV4       8'h03
`define PWCT_PRE_DIV16      8'h0F
`define PWCT_PRE_DIV64      8'h3F
`define PWCT_CLK_SEL_4      2'h0
`define PWCT_CLK_SEL_16     2'h1

// ****************************************
// input divider selection
// ****************************************
`define PWCT_DIV_OFF        3'h0
`define PWCT_DIV_4          3'h1
`define PWCT_DIV_16         3'h2
`define PWCT_DIV_64         3'h3
`define PWCT_DIV_256        3'h4
`define PWCT_DIVSEL_WIDTH   3

// ****************************************
// status and mask bits
// ****************************************
`define PWCT_ST_OVF         0
`define PWCT_ST_DONE        1
`define PWCT_ST_WIDTH       2

`define PWCT_CNT_WIDTH      16
`define PWCT_CNT_ZERO       16'h0000
`define PWCT_CNT_ONES       16'hFFFF

`endif

// ---- src/pwct_prescaler.v ----
// count clock prescaler giving a one-cycle tick at one of three rates
module pwct_prescaler
(
    input  wire       ref_clk,
    input  wire       srst,
    input  wire [1:0] clk_sel,
    output reg        tick
);

`include "pwct_map.vh"

    reg  [`PWCT_PRE_WIDTH-1:0] pre_cnt;
    reg  [`PWCT_PRE_WIDTH-1:0] terminal;

    // terminal count for the selected rate
    always @*
    begin
        case (clk_sel)
            `PWCT_CLK_SEL_4:  terminal = `PWCT_PRE_DIV4;
            `PWCT_CLK_SEL_16: terminal = `PWCT_PRE_DIV16;
            default:          terminal = `PWCT_PRE_DIV64;
        endcase
    end

    // free running divider; a rate change applies at once to the count in progress
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            pre_cnt <= {`PWCT_PRE_WIDTH{1'b0}};
            tick    <= 1'b0;
        end
        else if (pre_cnt >= terminal)
        begin
            pre_cnt <= {`PWCT_PRE_WIDTH{1'b0}};
            tick    <= 1'b1;
        end
        else
        begin
            pre_cnt <= pre_cnt + 1'b1;
            tick    <= 1'b0;
        end
    end

endmodule // pwct_prescaler

// ---- src/pwct_input_div.v ----
// input pulse divider: toggles its output every 2, 8, 32 or 128 input rising edges
`include "pwct_map.vh"
module pwct_input_div
(
    input  wire                          ref_clk,
    input  wire                          srst,
    input  wire [`PWCT_DIVSEL_WIDTH-1:0] div_sel,
    input  wire                          pulse_in,
    output reg                           pulse_out
);

    reg        pulse_in_d;
    reg  [7:0] div_cnt;
    reg  [7:0] half;
    wire       rise;

    assign rise = pulse_in & ~pulse_in_d;

    // half period less one in input edges, so a full output cycle spans the divide ratio
    always @*
    begin
        case (div_sel)
            `PWCT_DIV_4:  half = 8'h01;
            `PWCT_DIV_16: half = 8'h07;
            `PWCT_DIV_64: half = 8'h1F;
            default:      half = 8'h7F;
        endcase
    end

    // bypass passes the input straight through, one cycle late
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            pulse_in_d <= 1'b0;
            div_cnt    <= 8'h00;
            pulse_out  <= 1'b0;
        end
        else
        begin
            pulse_in_d <= pulse_in;
            if (div_sel == `PWCT_DIV_OFF)
            begin
                pulse_out <= pulse_in;
                div_cnt   <= 8'h00;
            end
            else if (rise)
            begin
                if (div_cnt >= half)
                begin
                    div_cnt   <= 8'h00;
                    pulse_out <= ~pulse_out;
                end
                else
                    div_cnt <= div_cnt + 8'h01;
            end
        end
    end

endmodule // pwct_input_div

// ---- src/pwct_timer.v ----
// pulse width counter timer: interval timer and input pulse measurement
// Notes on behaviour
// R1 - one 16-bit up counter serves both timer and measurement work
// R2 - interrupt on counter overflow and on end of a measurement
// R3 - timer mode raises a request at every software-set interval
// R4 - timer mode toggles the pulse output on each completed cycle
// R5 - counter clock picked by software from three internal rates
// R6 - high width rise to fall, low width fall to rise
// R7 - cycle measurement between rising edges or between falling edges
// R8 - edge mode counts from any edge to the next edge
// R9 - 8-bit input divider divides input by 4, 16, 64 or 256
// R10 - single measurement stops after one result, consecutive keeps going
// R11 - wrap from all ones sets overflow; timer restarts from reload value
//
// The register offsets and the address-and-strobe port were left to the implementer.
module pwct_timer
(
    input  wire        ref_clk,
    input  wire        srst,
    input  wire [3:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [15:0] rdata,
    input  wire        pulse_width_counter_in,
    output reg         pulse_width_counter_out,
    output wire        irq
);

`include "pwct_map.vh"

// ****************************************
// register map in brief
// ****************************************
    // ctrl: run, mode, count clock select, continuous
    // reload: value taken by the timer at each wrap
    // count: live counter, writable
    // result: last measured width or cycle, read only
    // status: overflow and done, sticky, cleared by a read
    // mask: per status bit enable onto the interrupt
    // divsel: input divider ratio, zero bypasses it

// ****************************************
// states and registers
// ****************************************
    localparam ST_IDLE  = 2'h0;
    localparam ST_ARM   = 2'h1;
    localparam ST_COUNT = 2'h2;

    reg  [`PWCT_CTRL_WIDTH-1:0]   ctrl;
    reg  [`PWCT_CNT_WIDTH-1:0]    reload;
    reg  [`PWCT_CNT_WIDTH-1:0]    count;
    reg  [`PWCT_CNT_WIDTH-1:0]    result;
    reg  [`PWCT_ST_WIDTH-1:0]     status;
    reg  [`PWCT_ST_WIDTH-1:0]     mask;
    reg  [`PWCT_DIVSEL_WIDTH-1:0] div_sel;
    reg  [1:0]                    state;
    reg  [1:0]                    next_state;
    reg                           sig_d;
    reg                           start_hit;
    reg                           stop_hit;
    reg                           done_ev;
    wire                          tick;
    wire                          sig;
    wire                          rise;
    wire                          fall;
    wire                          run;
    wire [2:0]                    mode;
    wire                          timer_mode;
    wire                          wrap;
    wire                          ovf_ev;

    assign run        = ctrl[`PWCT_CTRL_RUN];
    assign mode       = ctrl[`PWCT_CTRL_MODE_HI:`PWCT_CTRL_MODE_LO];
    assign timer_mode = (mode == `PWCT_MODE_TIMER);

    // measurement phases as flags, so counter and status logic read alike
    wire                          in_arm;
    wire                          in_count;
    assign in_arm   = (state == ST_ARM);
    assign in_count = (state == ST_COUNT);

// ****************************************
// register decode
// ****************************************
    // one strobe per writable register plus the status read; the bus never waits, so each is one cycle
    wire                          wr_ctrl;
    wire                          wr_reload;
    wire                          wr_count;
    wire                          wr_mask;
    wire                          wr_divsel;
    wire                          rd_status;

    assign wr_ctrl   = wr_en && (addr == `PWCT_ADDR_CTRL);
    assign wr_reload = wr_en && (addr == `PWCT_ADDR_RELOAD);
    assign wr_count  = wr_en && (addr == `PWCT_ADDR_COUNT);
    assign wr_mask   = wr_en && (addr == `PWCT_ADDR_MASK);
    assign wr_divsel = wr_en && (addr == `PWCT_ADDR_DIVSEL);
    assign rd_status = rd_en && (addr == `PWCT_ADDR_STATUS);

// ****************************************
// count clock and input divider
// ****************************************
    // three internal rates from the reference clock
    pwct_prescaler u_prescaler
    (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clk_sel (ctrl[`PWCT_CTRL_CLK_HI:`PWCT_CTRL_CLK_LO]), // R5
        .tick    (tick)
    );

    // divider only makes sense for cycle counts; it is applied to the input in any mode
    // it sits before edge detect, so every mode sees the same input delay
    pwct_input_div u_input_div
    (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .div_sel   (div_sel), // R9
        .pulse_in  (pulse_width_counter_in),
        .pulse_out (sig)
    );

    // edges of the divided input; low after reset, like an idle pin
    assign rise = sig & ~sig_d;
    assign fall = ~sig & sig_d;

    // previous level of the divided input
    always @(posedge ref_clk)
    begin
        if (srst)
            sig_d <= 1'b0;
        else
            sig_d <= sig;
    end

// ****************************************
// edge decode per measurement mode
// ****************************************
    // start and stop edges; cycle modes stop on the same edge kind that started
    // unknown mode codes never start, so the sequencer waits in arm with the counter held at zero
    always @*
    begin
        case (mode)
            `PWCT_MODE_HIGH:
            begin
                start_hit = rise; // R6
                stop_hit  = fall; // R6
            end
            `PWCT_MODE_LOW:
            begin
                start_hit = fall; // R6
                stop_hit  = rise; // R6
            end
            `PWCT_MODE_RISE_CYC:
            begin
                start_hit = rise; // R7
                stop_hit  = rise; // R7
            end
            `PWCT_MODE_FALL_CYC:
            begin
                start_hit = fall; // R7
                stop_hit  = fall; // R7
            end
            `PWCT_MODE_EDGE:
            begin
                start_hit = rise | fall; // R8
                stop_hit  = rise | fall; // R8
            end
            default:
            begin
                start_hit = 1'b0;
                stop_hit  = 1'b0;
            end
        endcase
    end

// ****************************************
// measurement sequencer
// ****************************************
    // idle until run, arm waits for start edge, count until stop edge
    always @*
    begin
        next_state = state;
        done_ev    = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (run && !timer_mode)
                    next_state = ST_ARM;
            end
            ST_ARM:
            begin
                if (!run || timer_mode)
                    next_state = ST_IDLE;
                else if (start_hit)
                    next_state = ST_COUNT;
            end
            ST_COUNT:
            begin
                if (!run || timer_mode)
                    next_state = ST_IDLE;
                else if (stop_hit)
                begin
                    done_ev = 1'b1;
                    // cycle modes may chain: the stop edge starts the next count
                    if (!ctrl[`PWCT_CTRL_CONT])
                        next_state = ST_IDLE; // R10
                    else if (start_hit)
                        next_state = ST_COUNT; // R10
                    else
                        next_state = ST_ARM; // R10
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // sequencer state register
    always @(posedge ref_clk)
    begin
        if (srst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

// ****************************************
// shared up counter
// ****************************************
    assign wrap   = tick && (count == `PWCT_CNT_ONES);
    // a timer cycle completes at wrap; measurement overflow is also a wrap
    assign ovf_ev = wrap && ((timer_mode && run) || in_count); // R11

    // one counter for both functions, counting on the selected tick
    // a software write to the counter wins over counting in the same cycle
    always @(posedge ref_clk)
    begin
        if (srst)
            count <= `PWCT_CNT_ZERO;
        else if (wr_count)
            count <= wdata;
        else if (timer_mode)
        begin
            if (run && tick)
                count <= wrap ? reload : count + 16'h0001; // R1 R3 R11
        end
        else if (in_arm || (in_count && stop_hit))
            count <= `PWCT_CNT_ZERO;
        else if (in_count && tick)
            count <= count + 16'h0001; // R1
    end

    // result latch and the timer pulse output
    // the result holds until the next completion, so it may be read late
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            result                  <= `PWCT_CNT_ZERO;
            pulse_width_counter_out <= 1'b0;
        end
        else
        begin
            if (done_ev)
                result <= count;
            if (!timer_mode)
                pulse_width_counter_out <= 1'b0;
            else if (ovf_ev)
                pulse_width_counter_out <= ~pulse_width_counter_out; // R4
        end
    end

// ****************************************
// register bus and interrupt
// ****************************************
    // writes to control, reload, mask and divider; run drops itself after a single result
    // a control write in the cycle of a completion wins, keeping software in charge
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            ctrl    <= `PWCT_CTRL_RESET;
            reload  <= `PWCT_CNT_ZERO;
            mask    <= {`PWCT_ST_WIDTH{1'b0}};
            div_sel <= `PWCT_DIV_OFF;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= wdata[`PWCT_CTRL_WIDTH-1:0];
            else if (done_ev && !ctrl[`PWCT_CTRL_CONT])
                ctrl[`PWCT_CTRL_RUN] <= 1'b0; // R10
            if (wr_reload)
                reload <= wdata;
            if (wr_mask)
                mask <= wdata[`PWCT_ST_WIDTH-1:0];
            if (wr_divsel)
                div_sel <= wdata[`PWCT_DIVSEL_WIDTH-1:0];
        end
    end

    // sticky status; a read clears it but an event in that cycle still lands
    always @(posedge ref_clk)
    begin
        if (srst)
            status <= {`PWCT_ST_WIDTH{1'b0}};
        else
        begin
            if (rd_status)
                status <= {`PWCT_ST_WIDTH{1'b0}};
            if (ovf_ev)
                status[`PWCT_ST_OVF] <= 1'b1; // R2 R11
            if (done_ev)
                status[`PWCT_ST_DONE] <= 1'b1; // R2
        end
    end

    // level interrupt while any unmasked sticky bit is set
    assign irq = |(status & mask); // R2

    // read data stand for exactly the cycle after the strobe; unmapped reads zero
    // zero outside the answer cycle lets an or-tree merge several slaves
    always @(posedge ref_clk)
    begin
        if (srst)
            rdata <= 16'h0000;
        else if (rd_en)
        begin
            case (addr)
                `PWCT_ADDR_CTRL:   rdata <= {9'h000, ctrl};
                `PWCT_ADDR_RELOAD: rdata <= reload;
                `PWCT_ADDR_COUNT:  rdata <= count;
                `PWCT_ADDR_RESULT: rdata <= result;
                `PWCT_ADDR_STATUS: rdata <= {14'h0000, status};
                `PWCT_ADDR_MASK:   rdata <= {14'h0000, mask};
                `PWCT_ADDR_DIVSEL: rdata <= {13'h0000, div_sel};
                default:           rdata <= 16'h0000;
            endcase
        end
        else
            rdata <= 16'h0000;
    end

endmodule // pwct_timer

// ---- dv/pwct_timer_properties.sv ----
// pin level checks of the pulse width counter timer
`include "pwct_map.vh"
module pwct_timer_properties
(
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [15:0] rdata,
    input wire logic        pulse_width_counter_in,
    input wire logic        pulse_width_counter_out,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // clocking and bus steps
    // ****
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_reload_wr;
        wr_en && addr == `PWCT_ADDR_RELOAD;
    endsequence
    sequence s_reload_rd;
        rd_en && addr == `PWCT_ADDR_RELOAD;
    endsequence
    // ****
    // assertions
    // ****
    rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    unmapped_zero_a: assert property (rd_en && addr > `PWCT_ADDR_DIVSEL |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    // reset must win even over a pending event, so no disable here
    reset_quiet_a: assert property (disable iff (1'b0)
        srst |=> rdata == 16'h0000 && !irq && !pulse_width_counter_out)
        else $error("outputs not quiet after reset");
    reload_back_a: assert property (s_reload_wr ##1 s_reload_rd |=> rdata == $past(wdata, 2))
        else $error("reload value not held");
    // ticks are at least four cycles apart, so the output cannot toggle faster
    out_spacing_a: assert property ($changed(pulse_width_counter_out) |=>
        $stable(pulse_width_counter_out) [*3])
        else $error("pulse output toggled too fast");
    mode_out_low_a: assert property (wr_en && addr == `PWCT_ADDR_CTRL &&
        wdata[3:1] != `PWCT_MODE_TIMER |=> ##[0:1] !pulse_width_counter_out)
        else $error("pulse output driven outside timer mode");
    irq_fall_a: assert property ($fell(irq) |->
        $past(rd_en && addr == `PWCT_ADDR_STATUS) || $past(wr_en))
        else $error("interrupt dropped without a read or write");
    mask_zero_a: assert property (wr_en && addr == `PWCT_ADDR_MASK && wdata[1:0] == 2'h0
        |=> !irq)
        else $error("interrupt high with mask cleared");
    status_shows_a: assert property (rd_en && addr == `PWCT_ADDR_STATUS && irq
        |=> rdata[1:0] != 2'h0)
        else $error("status read empty while interrupt high");
endmodule // pwct_timer_properties

// ---- dv/pwct_pulse_model.sv ----
// far side: pulse source on the measured input, load on the pulse output
module pwct_pulse_model
(
    input  wire logic ref_clk,
    output logic      pulse,
    input  wire logic load_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned toggles = 0;
    logic        load_d  = 1'b0;
    initial pulse = 1'b0;
    // load side: counts every level change of the timer output
    always @(posedge ref_clk)
    begin
        load_d <= load_in;
        if (load_in !== load_d)
            toggles <= toggles + 1;
    end
    // source: n periods of hi cycles high then lo cycles low, changed after the edge
    task automatic run_pattern(input int hi, input int lo, input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            pulse <= 1'b1;
            repeat (hi) @(posedge ref_clk);
            pulse <= 1'b0;
            repeat (lo - 1) @(posedge ref_clk);
        end
    endtask
endmodule // pwct_pulse_model

// ---- dv/tb_top.sv ----
// top bench: bus driver, read monitor, scenarios and verdict
`include "pwct_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; logic [15:0] lo; logic [15:0] hi; logic [15:0] m;} pwct_note_t;
    logic        ref_clk    = 1'b0;
    logic        srst       = 1'b1;
    logic [3:0]  addr       = 4'h0;
    logic [15:0] wdata      = 16'h0000;
    logic        wr_en      = 1'b0;
    logic        rd_en      = 1'b0;
    logic        rd_d       = 1'b0;
    logic [15:0] rdata;
    logic        pw_in;
    logic        pw_out;
    logic        irq;
    int          num_errors = 0;
    int          checks     = 0;
    pwct_note_t  notes[$];
    pwct_timer dut (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .pulse_width_counter_in(pw_in),
        .pulse_width_counter_out(pw_out), .irq(irq));
    pwct_pulse_model src (.ref_clk(ref_clk), .pulse(pw_in), .load_in(pw_out));
    always #12.5 ref_clk = ~ref_clk;
    // ****
    // helpers
    // ****
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // strobes stay up until the next call, so calls run back to back
    task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr_en <= w;
        rd_en <= r;
        addr  <= a;
        wdata <= d;
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 4'h0, 16'h0000);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    // a range note allows one tick of phase slip between prescaler and input edge
    task automatic rd(input string nm, input logic [3:0] a, input logic [15:0] lo,
                      input logic [15:0] hi, input logic [15:0] m);
        notes.push_back('{nm, lo, hi, m});
        bus(1'b0, 1'b1, a, 16'h0000);
    endtask
    task automatic wait_irq(input int n);
        for (int i = 0; i < n && irq !== 1'b1; i++)
            @(posedge ref_clk);
        check("irq_wait", 16'(irq), 16'h0001);
        if (irq !== 1'b1)
            print_verdict();
    endtask
    task automatic end_test(input string nm);
        idle(3);
        $display("test %s done", nm);
    endtask
    // monitor: the answer stands only in the cycle after the strobe
    always @(posedge ref_clk)
        rd_d <= rd_en;
    always @(negedge ref_clk)
    begin
        if (rd_d && notes.size() > 0)
        begin
            if (notes[0].lo == notes[0].hi)
                check(notes[0].nm, rdata & notes[0].m, notes[0].lo);
            else
                check(notes[0].nm, 16'(rdata >= notes[0].lo && rdata <= notes[0].hi), 16'h0001);
            void'(notes.pop_front());
        end
    end
    // ****
    // scenarios
    // ****
    initial
    begin
        int unsigned r;
        int          k;
        int          n;
        logic [15:0] ctl;
        void'($urandom(7005));
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        for (k = 0; k < 8; k++)
            rd("reset_value", k[3:0], 16'h0000, 16'h0000, 16'hFFFF);
        r = $urandom;
        wr(`PWCT_ADDR_RELOAD, r[15:0]);
        rd("reload_back", `PWCT_ADDR_RELOAD, r[15:0], r[15:0], 16'hFFFF);
        end_test("registers");
        // four ticks per wrap; a restart from zero would give no toggles at all
        wr(`PWCT_ADDR_RELOAD, 16'hFFFC);
        wr(`PWCT_ADDR_COUNT, 16'hFFFC);
        for (k = 0; k < 3; k++)
        begin
            n = 4 << (2 * k);
            wr(`PWCT_ADDR_CTRL, 16'h0001 | (16'(k) << `PWCT_CTRL_CLK_LO));
            idle(8 * n);
            r = src.toggles;
            idle(32 * n);
            check("toggles", 16'(src.toggles - r >= 7 && src.toggles - r <= 9), 16'h0001);
        end
        wr(`PWCT_ADDR_CTRL, 16'h0000);
        wr(`PWCT_ADDR_MASK, 16'h0000);
        idle(2);
        check("irq_masked", 16'(irq), 16'h0000);
        wr(`PWCT_ADDR_MASK, 16'h0001);
        idle(2);
        check("irq_raised", 16'(irq), 16'h0001);
        rd("status_ovf", `PWCT_ADDR_STATUS, 16'h0001, 16'h0001, 16'h0001);
        idle(2);
        check("irq_cleared", 16'(irq), 16'h0000);
        end_test("timer");
        wr(`PWCT_ADDR_MASK, 16'h0002);
        for (k = 1; k < 6; k++)
        begin
            ctl = 16'h0001 | (16'(k) << `PWCT_CTRL_MODE_LO);
            rd("status_clear", `PWCT_ADDR_STATUS, 16'h0000, 16'h0000, 16'h0003);
            wr(`PWCT_ADDR_CTRL, ctl);
            idle(4);
            check("out_low", 16'(pw_out), 16'h0000);
            src.run_pattern(40, 24, 3);
            wait_irq(50);
            n = (k == 2) ? 6 : (k == 3 || k == 4) ? 16 : 10;
            rd("width", `PWCT_ADDR_RESULT, 16'(n - 1), 16'(n + 1), 16'hFFFF);
            rd("done", `PWCT_ADDR_STATUS, 16'h0002, 16'h0002, 16'h0002);
            rd("single", `PWCT_ADDR_CTRL, ctl & 16'hFFFE, ctl & 16'hFFFE, 16'h007F);
        end
        ctl = 16'h0043;
        wr(`PWCT_ADDR_CTRL, ctl);
        idle(2);
        src.run_pattern(40, 24, 3);
        rd("cont_done", `PWCT_ADDR_STATUS, 16'h0002, 16'h0002, 16'h0002);
        rd("cont_run", `PWCT_ADDR_CTRL, ctl, ctl, 16'h007F);
        rd("cont_width", `PWCT_ADDR_RESULT, 16'h0009, 16'h000B, 16'hFFFF);
        idle(2);
        src.run_pattern(40, 24, 2);
        rd("cont_again", `PWCT_ADDR_STATUS, 16'h0002, 16'h0002, 16'h0002);
        wr(`PWCT_ADDR_CTRL, 16'h0000);
        idle(2);
        src.run_pattern(40, 24, 2);
        rd("stopped", `PWCT_ADDR_STATUS, 16'h0000, 16'h0000, 16'h0003);
        end_test("measure");
        // divided rise to rise spans n input periods of 8 cycles, 2n ticks
        for (k = 1; k < 5; k++)
        begin
            n = 1 << (2 * k);
            wr(`PWCT_ADDR_DIVSEL, 16'(k));
            rd("status_clear", `PWCT_ADDR_STATUS, 16'h0000, 16'h0000, 16'h0001);
            wr(`PWCT_ADDR_CTRL, 16'h0007);
            idle(2);
            src.run_pattern(4, 4, 3 * n);
            wait_irq(50);
            rd("div_cycle", `PWCT_ADDR_RESULT, 16'(2 * n - 1), 16'(2 * n + 1), 16'hFFFF);
        end
        wr(`PWCT_ADDR_DIVSEL, 16'h0000);
        end_test("divider");
        print_verdict();
    end
endmodule // tb_top
bind pwct_timer pwct_timer_properties u_props (.ref_clk(ref_clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .pulse_width_counter_in(pulse_width_counter_in),
    .pulse_width_counter_out(pulse_width_counter_out), .irq(irq));
